// file: shared/mlt_pkg.sv
package mlt_pkg;

    // Sample width and measurement count width
    localparam int SAMPLE_W = 16;
    localparam int COUNT_W = 7;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_VLEVEL = 8'h04;
    localparam logic [7:0] ADDR_VBAND = 8'h08;
    localparam logic [7:0] ADDR_CLEVEL = 8'h0C;
    localparam logic [7:0] ADDR_CBAND = 8'h10;
    localparam logic [7:0] ADDR_COUNT = 8'h14;
    localparam logic [7:0] ADDR_CMD = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_SEQ1 = 8'h20;
    localparam logic [7:0] ADDR_SEQ2 = 8'h24;
    localparam logic [7:0] ADDR_CAPV = 8'h28;
    localparam logic [7:0] ADDR_CAPC = 8'h2C;

    // Field positions
    localparam int CTRL_SRC_BIT = 0;
    localparam int CTRL_VSLOPE_LSB = 1;
    localparam int CTRL_CSLOPE_LSB = 3;
    localparam int CTRL_FUNC_BIT = 5;
    localparam int CMD_INIT_BIT = 0;
    localparam int CMD_ABORT_BIT = 1;
    localparam int CMD_TRG_BIT = 2;
    localparam int STAT_INIT_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_ERR_BIT = 2;
    localparam int STAT_REMAIN_LSB = 8;

    // Slope, source, function and state encodings
    typedef enum logic [1:0] {
        MLT_SLOPE_EITHER = 2'b00,
        MLT_SLOPE_POS = 2'b01,
        MLT_SLOPE_NEG = 2'b10
    } mlt_slope_e;
    typedef enum logic {
        MLT_SRC_INT = 1'b0,
        MLT_SRC_BUS = 1'b1
    } mlt_src_e;
    typedef enum logic {
        MLT_FUNC_VOLT = 1'b0,
        MLT_FUNC_CURR = 1'b1
    } mlt_func_e;
    typedef enum logic [1:0] {
        MLT_ST_IDLE = 2'b00,
        MLT_ST_ARMED = 2'b01,
        MLT_ST_MEASURE = 2'b10
    } mlt_state_e;
    typedef enum logic [1:0] {
        MLT_SIDE_NONE = 2'b00,
        MLT_SIDE_LOW = 2'b01,
        MLT_SIDE_HIGH = 2'b10
    } mlt_side_e;

    // Reset values and limits
    localparam logic [SAMPLE_W-1:0] LEVEL_RST = 16'h0000;
    localparam logic [SAMPLE_W-1:0] BAND_RST = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_RST = 7'h01;
    localparam logic [COUNT_W-1:0] COUNT_MIN = 7'h01;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 7'h64;
    localparam mlt_slope_e SLOPE_RST = MLT_SLOPE_EITHER;
    localparam mlt_src_e SRC_RST = MLT_SRC_INT;
    localparam mlt_func_e FUNC_RST = MLT_FUNC_VOLT;

    // Alias name codes of the two trigger sequences
    localparam logic [7:0] ALIAS_TRAN = 8'h01;
    localparam logic [7:0] ALIAS_ACQ = 8'h02;

endpackage

// file: shared/mlt_det_if.sv
`timescale 1ns/1ps
interface mlt_det_if #(parameter int W = 16);
    logic [W-1:0] sample;
    logic valid;
    logic [W-1:0] level;
    logic [W-1:0] band;
    logic rise;
    logic fall;
    modport det (input sample, input valid, input level, input band,
                 output rise, output fall);
    modport ctl (output sample, output valid, output level, output band,
                 input rise, input fall);
endinterface

// file: hw/mlt_detector.sv
`timescale 1ns/1ps
module mlt_detector #(
    parameter int W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    mlt_det_if.det det
);
    import mlt_pkg::*;

    mlt_side_e side;
    mlt_side_e next_side;
    logic rise;
    logic next_rise;
    logic fall;
    logic next_fall;
    logic signed [W+1:0] samp;
    logic signed [W+1:0] upper;
    logic signed [W+1:0] lower;
    logic above;
    logic below;

    // Band limits at level plus and minus half the band value
    always_comb begin
        samp = $signed({2'b00, det.sample});
        upper = $signed({2'b00, det.level})
              + $signed({3'b000, det.band[W-1:1]});
        lower = $signed({2'b00, det.level})
              - $signed({3'b000, det.band[W-1:1]});
        above = samp > upper;
        below = samp < lower;
    end

    // Remember settled side; fire only on a full crossing
    always_comb begin
        next_side = side;
        next_rise = 1'b0;
        next_fall = 1'b0;
        if (det.valid) begin
            if (below) begin
                next_side = MLT_SIDE_LOW;
                next_fall = (side == MLT_SIDE_HIGH);
            end else if (above) begin
                next_side = MLT_SIDE_HIGH;
                next_rise = (side == MLT_SIDE_LOW);
            end
        end
    end

    // Detector state registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            side <= MLT_SIDE_NONE;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            side <= next_side;
            rise <= next_rise;
            fall <= next_fall;
        end
    end

    assign det.rise = rise;
    assign det.fall = fall;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_rise;
        (det.valid && above && side == MLT_SIDE_LOW) |=> det.rise;
    endproperty
    a_rise: assert property (p_rise)
        else $error("rising crossing not reported");

    property p_fall;
        (det.valid && below && side == MLT_SIDE_HIGH) |=> det.fall;
    endproperty
    a_fall: assert property (p_fall)
        else $error("falling crossing not reported");

    property p_noarm;
        (side == MLT_SIDE_NONE) |=> !det.rise && !det.fall;
    endproperty
    a_noarm: assert property (p_noarm)
        else $error("crossing reported before a side settled");
endmodule

// file: hw/mlt_trigger.sv
// Operation
// - Rising voltage crossing: below lower to above upper
// - Falling voltage crossing: above upper to below lower
// - Voltage level zero to maximum, reset zero
// - Current slope: positive, negative, either; reset either
// - Voltage slope: same three settings; reset either
// - Positive rising, negative falling, either both
// - Source bus or internal; reset internal
// - Internal source fires on selected slope crossing
// - Bus trigger fires only with bus source
// - Sequence 1 transient, 2 acquire only
// - Query returns alias bound to each sequence
// - Trigger samples voltage, current into buffer
// - Band limits are level plus/minus half band
// - Re-arm after each measurement until count done
// - Not initiated: ignore all triggers
`timescale 1ns/1ps
module mlt_trigger #(
    parameter int W = mlt_pkg::SAMPLE_W,
    parameter logic [mlt_pkg::SAMPLE_W-1:0] VOLT_MAX = 16'hFFFF,
    parameter logic [mlt_pkg::SAMPLE_W-1:0] CURR_MAX = 16'hFFFF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [mlt_pkg::SAMPLE_W-1:0] volt_sample_i,
    input wire logic [mlt_pkg::SAMPLE_W-1:0] curr_sample_i,
    input wire logic sample_valid_i,
    input wire logic bus_trigger_i,
    input wire logic meas_done_i,
    output logic meas_start_o,
    output logic [mlt_pkg::SAMPLE_W-1:0] meas_volt_o,
    output logic [mlt_pkg::SAMPLE_W-1:0] meas_curr_o,
    output logic waiting_o
);
    import mlt_pkg::*;

    mlt_det_if #(.W(W)) vdet ();
    mlt_det_if #(.W(W)) cdet ();

    mlt_src_e src, next_src;
    mlt_func_e func, next_func;
    mlt_slope_e vslope, next_vslope;
    mlt_slope_e cslope, next_cslope;
    mlt_state_e state, next_state;
    logic [W-1:0] vlevel, next_vlevel;
    logic [W-1:0] vband, next_vband;
    logic [W-1:0] clevel, next_clevel;
    logic [W-1:0] cband, next_cband;
    logic [COUNT_W-1:0] count, next_count;
    logic [COUNT_W-1:0] remain, next_remain;
    logic [W-1:0] cap_v, next_cap_v;
    logic [W-1:0] cap_c, next_cap_c;
    logic alias_err, next_alias_err;
    logic start, next_start;
    logic ack, next_ack;
    logic [31:0] dat, next_dat;
    logic [31:0] rdata;
    logic [31:0] merged;
    logic wr;
    logic cmd_init;
    logic cmd_abort;
    logic cmd_trg;
    logic bus_hit;
    logic vhit;
    logic chit;
    logic int_hit;
    logic hit;

    // Byte-lane merge of a write onto the current word
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] din,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = din[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Clamp a written value to a model maximum
    function automatic logic [W-1:0] clamp_max(input logic [31:0] v,
                                               input logic [W-1:0] mx);
        logic [W-1:0] res;
        res = (v > {{(32-W){1'b0}}, mx}) ? mx : v[W-1:0];
        return res;
    endfunction

    // Crossing detectors for voltage and current
    assign vdet.sample = volt_sample_i;
    assign vdet.valid = sample_valid_i;
    assign vdet.level = vlevel;
    assign vdet.band = vband;
    assign cdet.sample = curr_sample_i;
    assign cdet.valid = sample_valid_i;
    assign cdet.level = clevel;
    assign cdet.band = cband;

    mlt_detector #(.W(W)) u_vdet (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .det(vdet)
    );

    mlt_detector #(.W(W)) u_cdet (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .det(cdet)
    );

    // Slope qualification and source selection
    always_comb begin
        vhit = (vdet.rise && vslope != MLT_SLOPE_NEG)
             || (vdet.fall && vslope != MLT_SLOPE_POS);
        chit = (cdet.rise && cslope != MLT_SLOPE_NEG)
             || (cdet.fall && cslope != MLT_SLOPE_POS);
        int_hit = (func == MLT_FUNC_CURR) ? chit : vhit;
        bus_hit = bus_trigger_i || cmd_trg;
        hit = (src == MLT_SRC_BUS) ? bus_hit : int_hit;
    end

    // Read mux; sequence aliases are fixed names
    always_comb begin
        rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            ADDR_CTRL: begin
                rdata[CTRL_SRC_BIT] = src;
                rdata[CTRL_VSLOPE_LSB +: 2] = vslope;
                rdata[CTRL_CSLOPE_LSB +: 2] = cslope;
                rdata[CTRL_FUNC_BIT] = func;
            end
            ADDR_VLEVEL: rdata[W-1:0] = vlevel;
            ADDR_VBAND: rdata[W-1:0] = vband;
            ADDR_CLEVEL: rdata[W-1:0] = clevel;
            ADDR_CBAND: rdata[W-1:0] = cband;
            ADDR_COUNT: rdata[COUNT_W-1:0] = count;
            ADDR_STATUS: begin
                rdata[STAT_INIT_BIT] = (state != MLT_ST_IDLE);
                rdata[STAT_BUSY_BIT] = (state == MLT_ST_MEASURE);
                rdata[STAT_ERR_BIT] = alias_err;
                rdata[STAT_REMAIN_LSB +: COUNT_W] = remain;
            end
            ADDR_SEQ1: rdata[7:0] = ALIAS_TRAN;
            ADDR_SEQ2: rdata[7:0] = ALIAS_ACQ;
            ADDR_CAPV: rdata[W-1:0] = cap_v;
            ADDR_CAPC: rdata[W-1:0] = cap_c;
            default: rdata = 32'h0000_0000;
        endcase
    end

    // Bus decode, register writes and trigger sequencing
    always_comb begin
        wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
        merged = lane_merge(rdata, wb_dat_i, wb_sel_i);
        next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_dat = (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
                 ? rdata : 32'h0000_0000;
        next_src = src;
        next_func = func;
        next_vslope = vslope;
        next_cslope = cslope;
        next_vlevel = vlevel;
        next_vband = vband;
        next_clevel = clevel;
        next_cband = cband;
        next_count = count;
        next_alias_err = alias_err;
        cmd_init = 1'b0;
        cmd_abort = 1'b0;
        cmd_trg = 1'b0;
        if (wr) begin
            unique case (wb_adr_i)
                ADDR_CTRL: begin
                    next_src = mlt_src_e'(merged[CTRL_SRC_BIT]);
                    next_func = mlt_func_e'(merged[CTRL_FUNC_BIT]);
                    // Unused slope code keeps the previous setting
                    if (merged[CTRL_VSLOPE_LSB +: 2] != 2'b11) begin
                        next_vslope =
                            mlt_slope_e'(merged[CTRL_VSLOPE_LSB +: 2]);
                    end
                    if (merged[CTRL_CSLOPE_LSB +: 2] != 2'b11) begin
                        next_cslope =
                            mlt_slope_e'(merged[CTRL_CSLOPE_LSB +: 2]);
                    end
                end
                ADDR_VLEVEL:
                    next_vlevel = clamp_max(merged, VOLT_MAX);
                ADDR_VBAND: next_vband = clamp_max(merged, VOLT_MAX);
                ADDR_CLEVEL: next_clevel = clamp_max(merged, CURR_MAX);
                ADDR_CBAND: next_cband = clamp_max(merged, CURR_MAX);
                ADDR_COUNT: begin
                    if (merged < {25'h0, COUNT_MIN}) begin
                        next_count = COUNT_MIN;
                    end else if (merged > {25'h0, COUNT_MAX}) begin
                        next_count = COUNT_MAX;
                    end else begin
                        next_count = merged[COUNT_W-1:0];
                    end
                end
                ADDR_CMD: begin
                    cmd_init = merged[CMD_INIT_BIT];
                    cmd_abort = merged[CMD_ABORT_BIT];
                    cmd_trg = merged[CMD_TRG_BIT];
                end
                ADDR_STATUS: begin
                    if (wb_sel_i[0] && wb_dat_i[STAT_ERR_BIT]) begin
                        next_alias_err = 1'b0;
                    end
                end
                default: begin
                end
            endcase
            // Wrong alias is rejected and flagged; set beats clear
            if ((wb_adr_i == ADDR_SEQ1 && merged[7:0] != ALIAS_TRAN)
                || (wb_adr_i == ADDR_SEQ2 && merged[7:0] != ALIAS_ACQ)) begin
                next_alias_err = 1'b1;
            end
        end
    end

    // Trigger sequencer: arm, measure, re-arm until count done
    always_comb begin
        next_state = state;
        next_remain = remain;
        next_start = 1'b0;
        next_cap_v = cap_v;
        next_cap_c = cap_c;
        unique case (state)
            MLT_ST_IDLE: begin
                // Triggers are dropped until initiated
                if (cmd_init) begin
                    next_state = MLT_ST_ARMED;
                    next_remain = count;
                end
            end
            MLT_ST_ARMED: begin
                if (cmd_abort) begin
                    next_state = MLT_ST_IDLE;
                    next_remain = '0;
                end else if (hit) begin
                    next_state = MLT_ST_MEASURE;
                    next_start = 1'b1;
                    next_cap_v = volt_sample_i;
                    next_cap_c = curr_sample_i;
                end
            end
            MLT_ST_MEASURE: begin
                if (cmd_abort) begin
                    next_state = MLT_ST_IDLE;
                    next_remain = '0;
                end else if (meas_done_i) begin
                    if (remain <= COUNT_MIN) begin
                        next_state = MLT_ST_IDLE;
                        next_remain = '0;
                    end else begin
                        next_state = MLT_ST_ARMED;
                        next_remain = remain - COUNT_MIN;
                    end
                end
            end
            default: begin
                next_state = MLT_ST_IDLE;
                next_remain = '0;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src <= SRC_RST;
            func <= FUNC_RST;
            vslope <= SLOPE_RST;
            cslope <= SLOPE_RST;
            vlevel <= LEVEL_RST;
            vband <= BAND_RST;
            clevel <= LEVEL_RST;
            cband <= BAND_RST;
            count <= COUNT_RST;
            remain <= '0;
            state <= MLT_ST_IDLE;
            cap_v <= '0;
            cap_c <= '0;
            alias_err <= 1'b0;
            start <= 1'b0;
            ack <= 1'b0;
            dat <= 32'h0000_0000;
        end else begin
            src <= next_src;
            func <= next_func;
            vslope <= next_vslope;
            cslope <= next_cslope;
            vlevel <= next_vlevel;
            vband <= next_vband;
            clevel <= next_clevel;
            cband <= next_cband;
            count <= next_count;
            remain <= next_remain;
            state <= next_state;
            cap_v <= next_cap_v;
            cap_c <= next_cap_c;
            alias_err <= next_alias_err;
            start <= next_start;
            ack <= next_ack;
            dat <= next_dat;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = dat;
    assign meas_start_o = start;
    assign meas_volt_o = cap_v;
    assign meas_curr_o = cap_c;
    assign waiting_o = (state == MLT_ST_ARMED);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_bus_fire;
        (state == MLT_ST_ARMED && !cmd_abort && src == MLT_SRC_BUS
         && bus_hit) |=> meas_start_o && state == MLT_ST_MEASURE;
    endproperty
    a_bus_fire: assert property (p_bus_fire)
        else $error("bus trigger did not start a measurement");

    property p_bus_block;
        (state == MLT_ST_ARMED && src == MLT_SRC_INT && bus_hit
         && !int_hit) |=> !meas_start_o;
    endproperty
    a_bus_block: assert property (p_bus_block)
        else $error("bus trigger fired with internal source");

    property p_int_fire;
        (state == MLT_ST_ARMED && !cmd_abort && src == MLT_SRC_INT
         && int_hit) |=> meas_start_o ##1 !meas_start_o;
    endproperty
    a_int_fire: assert property (p_int_fire)
        else $error("internal crossing did not give one start pulse");

    property p_slope_pos;
        (vslope == MLT_SLOPE_POS && func == MLT_FUNC_VOLT && vdet.fall
         && !vdet.rise) |-> !int_hit;
    endproperty
    a_slope_pos: assert property (p_slope_pos)
        else $error("positive slope fired on a falling crossing");

    property p_idle_quiet;
        (state == MLT_ST_IDLE) |=> !meas_start_o;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("trigger accepted while not initiated");

    property p_rearm;
        (state == MLT_ST_MEASURE && !cmd_abort && meas_done_i
         && remain > COUNT_MIN)
        |=> state == MLT_ST_ARMED && remain == $past(remain) - COUNT_MIN;
    endproperty
    a_rearm: assert property (p_rearm)
        else $error("no re-arm after measurement");

    property p_count_end;
        (state == MLT_ST_MEASURE && meas_done_i && remain == COUNT_MIN)
        |=> state == MLT_ST_IDLE;
    endproperty
    a_count_end: assert property (p_count_end)
        else $error("sequence did not stop after last count");

    property p_count_range;
        count >= COUNT_MIN && count <= COUNT_MAX && vlevel <= VOLT_MAX;
    endproperty
    a_count_range: assert property (p_count_range)
        else $error("count or level outside its range");

    property p_alias_rej;
        (wr && wb_adr_i == ADDR_SEQ2 && merged[7:0] != ALIAS_ACQ)
        |=> alias_err;
    endproperty
    a_alias_rej: assert property (p_alias_rej)
        else $error("wrong sequence alias was not rejected");

    property p_capture;
        meas_start_o |-> meas_volt_o == $past(volt_sample_i);
    endproperty
    a_capture: assert property (p_capture)
        else $error("voltage sample not stored at trigger");
endmodule

// file: dv/mlt_sampler_model.sv
`timescale 1ns/1ps
// Sampler model: ends each measurement a fixed time after its start
module mlt_sampler_model #(
    parameter int DLY = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic meas_start_i,
    output logic meas_done_o
);
    int cnt;
    // Count down from the start pulse, pulse done when it runs out
    always_ff @(posedge clk_i) begin
        meas_done_o <= 1'b0;
        if (rst_i) begin
            cnt <= 0;
        end else if (meas_start_i) begin
            cnt <= DLY;
        end else if (cnt == 1) begin
            cnt <= 0;
            meas_done_o <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// file: dv/measurement_level_trigger_tb.sv
`timescale 1ns/1ps
module measurement_level_trigger_tb;
    import mlt_pkg::*;
    localparam logic [15:0] VMAX = 16'hF000;
    logic clk_i, rst_i, cyc, stb, we, sv, bt, ack, st, done, wt;
    logic [7:0] adr;
    logic [31:0] dat, rdat, e;
    logic [15:0] vs, cs, mv, mc, lvl, bnd, lo, hi;
    logic [31:0] rd_q[$], st_q[$];
    int fails, samples_checked;
    mlt_trigger #(.VOLT_MAX(VMAX)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .volt_sample_i(vs), .curr_sample_i(cs), .sample_valid_i(sv),
        .bus_trigger_i(bt), .meas_done_i(done), .meas_start_o(st),
        .meas_volt_o(mv), .meas_curr_o(mc), .waiting_o(wt));
    mlt_sampler_model u_smp (.clk_i(clk_i), .rst_i(rst_i),
        .meas_start_i(st), .meas_done_o(done));
    // Clock at 125 MHz
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (fails == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Classic Wishbone cycle, raised after an edge, held until ack is seen
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        rd_q.push_back(x);
        wb(1'b0, a, 32'h0);
    endtask
    // Present one sample to both channels, then let the sampler finish
    task automatic samp(input logic [15:0] v);
        @(posedge clk_i);
        vs <= v;
        cs <= v;
        sv <= 1'b1;
        @(posedge clk_i);
        sv <= 1'b0;
        repeat (16) @(posedge clk_i);
    endtask
    task automatic trg();
        @(posedge clk_i);
        bt <= 1'b1;
        @(posedge clk_i);
        bt <= 1'b0;
        repeat (16) @(posedge clk_i);
    endtask
    // Oldest note is taken off whenever a result appears
    always @(negedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) begin
            e = rd_q.size() ? rd_q.pop_front() : 'x;
            check(rdat, e);
        end
        if (st === 1'b1) begin
            e = st_q.size() ? st_q.pop_front() : 'x;
            check({mv, mc}, e);
        end
    end
    // Watchdog
    initial begin
        #200000;
        fails++;
        final_report();
    end
    initial begin
        {cyc, stb, we, sv, bt, adr, dat, vs, cs} = '0;
        fails = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        void'($urandom(99));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADDR_CTRL, 0);
        rd(ADDR_VLEVEL, 0);
        rd(ADDR_COUNT, 1);
        rd(ADDR_SEQ1, ALIAS_TRAN);
        rd(ADDR_SEQ2, ALIAS_ACQ);
        rd(8'h30, 0);
        // Unused slope code keeps the stored setting
        wb(1, ADDR_CTRL, 3 << CTRL_VSLOPE_LSB);
        rd(ADDR_CTRL, 0);
        wb(1, ADDR_SEQ1, ALIAS_TRAN);
        rd(ADDR_STATUS, 0);
        wb(1, ADDR_SEQ2, ALIAS_TRAN);
        rd(ADDR_STATUS, 1 << STAT_ERR_BIT);
        rd(ADDR_SEQ2, ALIAS_ACQ);
        wb(1, ADDR_STATUS, 1 << STAT_ERR_BIT);
        rd(ADDR_STATUS, 0);
        wb(1, ADDR_VLEVEL, 32'hFFFF);
        rd(ADDR_VLEVEL, VMAX);
        wb(1, ADDR_COUNT, 0);
        rd(ADDR_COUNT, 1);
        wb(1, ADDR_COUNT, 32'h7F);
        rd(ADDR_COUNT, 32'h64);
        // Bus source: ignored until initiated, then count of two
        samp(16'h0123);
        wb(1, ADDR_CTRL, 1 << CTRL_SRC_BIT);
        trg();
        wb(1, ADDR_COUNT, 2);
        wb(1, ADDR_CMD, 1 << CMD_INIT_BIT);
        check(wt, 1'b1);
        st_q.push_back(32'h01230123);
        trg();
        st_q.push_back(32'h01230123);
        wb(1, ADDR_CMD, 1 << CMD_TRG_BIT);
        repeat (16) @(posedge clk_i);
        trg();
        check(wt, 1'b0);
        // Internal source: every function and slope
        for (int f = 0; f < 2; f++) begin
            for (int s = 0; s < 3; s++) begin
                lvl = 16'h1000 + 16'($urandom % 32'h4000);
                bnd = 16'($urandom % 32'h0400);
                lo = lvl - (bnd >> 1) - 16'h1;
                hi = lvl + (bnd >> 1) + 16'h1;
                wb(1, f ? ADDR_CLEVEL : ADDR_VLEVEL, {16'h0, lvl});
                wb(1, f ? ADDR_CBAND : ADDR_VBAND, {16'h0, bnd});
                wb(1, ADDR_CTRL, (f << CTRL_FUNC_BIT) |
                   (s << (f ? CTRL_CSLOPE_LSB : CTRL_VSLOPE_LSB)));
                samp(lo);
                wb(1, ADDR_CMD, 1 << CMD_INIT_BIT);
                trg();
                if (s != 2) st_q.push_back({hi, hi});
                samp(hi);
                if (s != 1) st_q.push_back({lo, lo});
                samp(lo);
                wb(1, ADDR_CMD, 1 << CMD_ABORT_BIT);
                check(wt, 1'b0);
            end
        end
        repeat (4) @(posedge clk_i);
        check(st_q.size(), 0);
        final_report();
    end
endmodule
